// ===== design/ucb_defines.vh
// Constants for the serial port control and break logic.
// Assumes a 100 MHz bus clock and the plain strobe register port.
// Contract
// - Control register readable and writable at any time
// - Tx empty enable gates interrupt from flag
// - Tx complete enable gates interrupt from flag
// - Rx full enable gates interrupt from flag
// - Idle line enable gates interrupt from flag
// - Transmit enable owns and drives transmit pin
// - Single wire: direction bit steers shared pin
// - Enable off then on mid-frame queues idle
// - Pin kept until pending characters finish
// - Receive enable off releases receive pin
// - Loop select always releases receive pin
// - Writing standby one waits for wakeup
// - Wakeup: idle line or address mark bit
// - Hardware clears standby on wakeup condition
// - Break bit one then zero queues break
// - Break held: repeat breaks, 10/11 or 13/14 bits
// - Second break may be queued; either accepted
// - Status register read only, writes ignored
// - Flags cleared only by read sequences; code also clears Tx complete when any character starts
// - Length select: 8 or 9 data bits
// - Loop: internal loopback or single wire
// - Tx empty set at reset and on load
// - Tx complete set when transmitter idle
`ifndef UCB_DEFINES_VH
`define UCB_DEFINES_VH
// Register indices
`define UCB_ADDR_BDH 3'h0
`define UCB_ADDR_BDL 3'h1
`define UCB_ADDR_C1 3'h2
`define UCB_ADDR_C2 3'h3
`define UCB_ADDR_S1 3'h4
`define UCB_ADDR_S2 3'h5
`define UCB_ADDR_C3 3'h6
`define UCB_ADDR_DATA 3'h7
// Control two field positions
`define UCB_C2_TIE 7
`define UCB_C2_TX_COMPLETE_IRQ_EN 6
`define UCB_C2_RIE 5
`define UCB_C2_IDLE_LINE_IRQ_EN 4
`define UCB_C2_TE 3
`define UCB_C2_RE 2
`define UCB_C2_RWU 1
`define UCB_C2_SBK 0
// Control one field positions
`define UCB_C1_LOOP 7
`define UCB_C1_RX_SOURCE_SELECT 5
`define UCB_C1_M 4
`define UCB_C1_WAKE 3
// Status two: long break select position
`define UCB_S2_LONG_BREAK_SELECT 2
// Control three: single wire direction position
`define UCB_C3_SINGLE_WIRE_DIRECTION 5
// Reset values
`define UCB_C1_RST 8'h00
`define UCB_C2_RST 8'h00
`define UCB_BD_RST 13'h0004
`define UCB_C3_RST 8'h00
`endif

// ===== design/ucb_baud.v
// Baud tick generator: one-cycle tick per bit time.
// Assumes the divisor is stable while the transmitter runs.
`timescale 1ns/1ps
`default_nettype none
module ucb_baud (
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  input wire [12:0] divisor,
  output reg bit_tick_ff
);
  // Counts divisor times sixteen bus cycles per bit
  reg [16:0] cnt_ff;
  wire [16:0] span = {divisor, 4'h0};
  // Zero divisor stops the generator to save power
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= 17'h00000;
      bit_tick_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (divisor == 13'h0000)
      begin
        cnt_ff <= 17'h00000;
        bit_tick_ff <= 1'b0;
      end
      else if (cnt_ff >= span - 17'h00001)
      begin
        cnt_ff <= 17'h00000;
        bit_tick_ff <= 1'b1;
      end
      else
      begin
        cnt_ff <= cnt_ff + 17'h00001;
        bit_tick_ff <= 1'b0;
      end
    end
  end
endmodule // ucb_baud
`default_nettype wire

// ===== design/ucb_txshift.v
// Transmit shifter: sends a data, idle or break character.
// Assumes the caller starts it only when it is not busy.
`timescale 1ns/1ps
`default_nettype none
module ucb_txshift (
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  input wire bit_tick,
  input wire start,
  input wire [1:0] kind,
  input wire [8:0] data,
  input wire nine_bit,
  input wire long_break,
  output reg line_ff,
  output reg busy_ff
);
  // Kind codes: 0 data, 1 idle, 2 break
  reg [10:0] shreg_ff;
  reg [3:0] left_ff;
  reg [3:0] len;
  // Break in progress; kind is only valid in the start cycle, so it is kept here
  reg brk_ff;
  // Character length in bit times
  always @*
  begin
    len = nine_bit ? 4'hb : 4'ha;
    if (kind == 2'h2)
      len = len + (long_break ? 4'h3 : 4'h0);
  end
  // Shift out LSB first, start bit first
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shreg_ff <= 11'h7ff;
      left_ff <= 4'h0;
      line_ff <= 1'b1;
      busy_ff <= 1'b0;
      brk_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start && !busy_ff)
      begin
        busy_ff <= 1'b1;
        left_ff <= len;
        brk_ff <= (kind == 2'h2);
        case (kind)
          2'h0: shreg_ff <= nine_bit ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
          2'h1: shreg_ff <= 11'h7ff;
          default: shreg_ff <= 11'h000;
        endcase
      end
      else if (busy_ff && bit_tick)
      begin
        // Breaks keep low for all bits; a long break outlasts the register, so zeros are filled in
        line_ff <= shreg_ff[0];
        shreg_ff <= {!brk_ff, shreg_ff[10:1]};
        left_ff <= left_ff - 4'h1;
        if (left_ff == 4'h0)
        begin
          busy_ff <= 1'b0;
          line_ff <= 1'b1;
        end
      end
    end
  end
endmodule // ucb_txshift
`default_nettype wire

// ===== design/ucb_ctrl.v
// Serial port control register, pin ownership, queued idle and break.
// Assumes the receive datapath supplies flags and wakeup events.
// Register port: write strobe one cycle; read data the next cycle.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ucb_defines.vh"
module ucb_ctrl (
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  input wire rx_buffer_full,
  input wire idle_flag,
  input wire [4:0] rx_error_flags,
  input wire rx_idle_detect,
  input wire rx_msb_mark,
  input wire rx_char_done,
  input wire txd_in,
  output wire txd_out,
  output wire txd_oe,
  output wire rxd_owned,
  output wire rx_active,
  output wire rx_line,
  output wire irq
);
  // Software-visible registers
  reg [7:0] uart_control_two_ff; // Interrupt enables, enables, standby, break
  reg [7:0] ctrl_one_ff; // Loop, source, length, wake method
  reg [12:0] baud_ff; // Baud divisor
  reg [7:0] ctrl_three_ff; // Single wire direction
  reg long_break_select_ff; // Long break option
  reg [8:0] tx_buf_ff; // Transmit buffer
  // Transmitter state
  reg tx_buffer_empty_ff; // Buffer has room
  reg tx_complete_ff; // Transmitter idle
  reg idle_queued_ff; // Queued idle pending
  reg break_queued_ff; // Queued break pending
  reg tx_own_ff; // Transmitter still owns the pin
  reg status_seen_ff; // Status read armed flag clear
  reg rx_standby_clr; // Hardware wakeup of standby
  // Transmit scheduler states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  reg [2:0] st_ff;
  reg [2:0] nxt_st;
  reg start_tx;
  reg [1:0] start_kind;
  wire bit_tick;
  wire shift_line;
  wire shift_busy;
  // Decoded control fields
  wire transmit_enable = uart_control_two_ff[`UCB_C2_TE];
  wire receive_enable = uart_control_two_ff[`UCB_C2_RE];
  wire send_break = uart_control_two_ff[`UCB_C2_SBK];
  wire rx_standby = uart_control_two_ff[`UCB_C2_RWU];
  wire loop_select = ctrl_one_ff[`UCB_C1_LOOP];
  wire rx_source_select = ctrl_one_ff[`UCB_C1_RX_SOURCE_SELECT];
  wire single_wire_direction = ctrl_three_ff[`UCB_C3_SINGLE_WIRE_DIRECTION];
  wire single_wire = loop_select && rx_source_select;
  wire wr_c2 = reg_wr && (reg_addr == `UCB_ADDR_C2);
  wire wr_data = reg_wr && (reg_addr == `UCB_ADDR_DATA);
  wire rd_s1 = reg_rd && (reg_addr == `UCB_ADDR_S1);
  wire rd_data = reg_rd && (reg_addr == `UCB_ADDR_DATA);
  wire [7:0] status_one = {tx_buffer_empty_ff, tx_complete_ff, rx_buffer_full, idle_flag, rx_error_flags[3:0]};
  wire te_rise = wr_c2 && reg_wdata[`UCB_C2_TE] && !transmit_enable;
  wire sbk_fall = wr_c2 && !reg_wdata[`UCB_C2_SBK] && send_break;
  wire sbk_rise = wr_c2 && reg_wdata[`UCB_C2_SBK] && !send_break;

  ucb_baud u_baud (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .divisor(baud_ff),
    .bit_tick_ff(bit_tick)
  );

  ucb_txshift u_shift (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .bit_tick(bit_tick),
    .start(start_tx),
    .kind(start_kind),
    .data(tx_buf_ff),
    .nine_bit(ctrl_one_ff[`UCB_C1_M]),
    .long_break(long_break_select_ff),
    .line_ff(shift_line),
    .busy_ff(shift_busy)
  );

  // Software writes; standby cleared by hardware wins over a write of the same cycle
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uart_control_two_ff <= `UCB_C2_RST;
      ctrl_one_ff <= `UCB_C1_RST;
      baud_ff <= `UCB_BD_RST;
      ctrl_three_ff <= `UCB_C3_RST;
      long_break_select_ff <= 1'b0;
      tx_buf_ff <= 9'h000;
    end
    else if (clk_en)
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `UCB_ADDR_BDH: baud_ff[12:8] <= reg_wdata[4:0];
          `UCB_ADDR_BDL: baud_ff[7:0] <= reg_wdata;
          `UCB_ADDR_C1: ctrl_one_ff <= reg_wdata;
          `UCB_ADDR_C2: uart_control_two_ff <= reg_wdata;
          `UCB_ADDR_S2: long_break_select_ff <= reg_wdata[`UCB_S2_LONG_BREAK_SELECT];
          `UCB_ADDR_C3: ctrl_three_ff <= reg_wdata;
          `UCB_ADDR_DATA: tx_buf_ff <= {ctrl_three_ff[6], reg_wdata};
          default: ; // Status one writes are ignored
        endcase
      end
      if (rx_standby_clr)
        uart_control_two_ff[`UCB_C2_RWU] <= 1'b0;
    end
  end

  // Wakeup condition select
  always @*
  begin
    if (ctrl_one_ff[`UCB_C1_WAKE])
      rx_standby_clr = rx_standby && rx_char_done && rx_msb_mark;
    else
      rx_standby_clr = rx_standby && rx_idle_detect;
  end

  // Transmit scheduler: break first, then idle, then data
  always @*
  begin
    nxt_st = st_ff;
    start_tx = 1'b0;
    start_kind = 2'h0;
    case (st_ff)
      ST_IDLE:
        // Still owning the pin after the enable drops lets pending work drain
        if ((transmit_enable || tx_own_ff) && (break_queued_ff || idle_queued_ff || !tx_buffer_empty_ff))
          nxt_st = ST_LOAD;
      ST_LOAD:
      begin
        start_tx = 1'b1;
        start_kind = break_queued_ff ? 2'h2 : (idle_queued_ff ? 2'h1 : 2'h0);
        nxt_st = ST_RUN;
      end
      ST_RUN:
        if (!shift_busy)
          nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Queues, flags and ownership
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= ST_IDLE;
      tx_buffer_empty_ff <= 1'b1;
      tx_complete_ff <= 1'b1;
      idle_queued_ff <= 1'b0;
      break_queued_ff <= 1'b0;
      tx_own_ff <= 1'b0;
      status_seen_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
      // Status read arms the clear; data write, enable edge or break edge finishes it
      if (rd_s1)
        status_seen_ff <= 1'b1;
      else if (wr_data || te_rise || sbk_rise)
        status_seen_ff <= 1'b0;
      // Loading the buffer empties it; a write after a status read refills it
      if (start_tx && start_kind == 2'h0)
        tx_buffer_empty_ff <= 1'b1;
      else if (wr_data && status_seen_ff)
        tx_buffer_empty_ff <= 1'b0;
      // Queued idle: enable written off then on while busy
      if (te_rise && (shift_busy || st_ff != ST_IDLE || tx_own_ff))
        idle_queued_ff <= 1'b1;
      else if (start_tx && start_kind == 2'h1)
        idle_queued_ff <= 1'b0;
      // Break queued on clear; held bit requeues after each break
      // A transmitter that is off queues no break, so no stale break appears at the next enable
      if ((sbk_fall && transmit_enable) || (send_break && st_ff == ST_IDLE && transmit_enable))
        break_queued_ff <= 1'b1;
      else if (start_tx && start_kind == 2'h2)
        break_queued_ff <= 1'b0;
      // Complete when nothing is pending or running
      if (start_tx || (wr_data && status_seen_ff))
        tx_complete_ff <= 1'b0;
      else if (st_ff == ST_IDLE && tx_buffer_empty_ff && !idle_queued_ff && !break_queued_ff)
        tx_complete_ff <= 1'b1;
      // Pin kept until all pending characters finish
      if (transmit_enable)
        tx_own_ff <= 1'b1;
      else if (st_ff == ST_IDLE && tx_buffer_empty_ff && !idle_queued_ff && !break_queued_ff)
        tx_own_ff <= 1'b0;
      // Read data one cycle after the strobe
      if (reg_rd)
      begin
        case (reg_addr)
          `UCB_ADDR_BDH: reg_rdata_ff <= {3'h0, baud_ff[12:8]};
          `UCB_ADDR_BDL: reg_rdata_ff <= baud_ff[7:0];
          `UCB_ADDR_C1: reg_rdata_ff <= ctrl_one_ff;
          `UCB_ADDR_C2: reg_rdata_ff <= uart_control_two_ff;
          `UCB_ADDR_S1: reg_rdata_ff <= status_one;
          `UCB_ADDR_S2: reg_rdata_ff <= {5'h00, long_break_select_ff, 2'h0};
          `UCB_ADDR_C3: reg_rdata_ff <= ctrl_three_ff;
          default: reg_rdata_ff <= 8'h00;
        endcase
      end
      else
        reg_rdata_ff <= 8'h00;
    end
  end

  // Pin drive: owned while enabled or draining; single wire steered by direction
  assign txd_out = shift_line;
  assign txd_oe = (tx_own_ff || transmit_enable) && (!single_wire || single_wire_direction);
  // Receive pin released when off or in any loop mode
  assign rxd_owned = receive_enable && !loop_select;
  assign rx_active = receive_enable;
  // Receiver input source
  assign rx_line = !loop_select ? 1'b1 : (rx_source_select ? txd_in : shift_line);
  // One merged interrupt request line
  assign irq = (uart_control_two_ff[`UCB_C2_TIE] && tx_buffer_empty_ff)
    || (uart_control_two_ff[`UCB_C2_TX_COMPLETE_IRQ_EN] && tx_complete_ff)
    || (uart_control_two_ff[`UCB_C2_RIE] && rx_buffer_full)
    || (uart_control_two_ff[`UCB_C2_IDLE_LINE_IRQ_EN] && idle_flag);
  wire unused_ok = rd_data | rx_error_flags[4];
endmodule // ucb_ctrl
`default_nettype wire

// ===== tb/ucb_ctrl_sva.sv
// Checker for the serial port control block, bound to ucb_ctrl.
// Assumes control one and two are shadowed from bus writes only.
`timescale 1ns/1ps
`default_nettype none
module ucb_ctrl_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic rx_buffer_full,
  input wire logic idle_flag,
  input wire logic txd_oe,
  input wire logic rxd_owned,
  input wire logic rx_active,
  input wire logic irq
);
  logic [7:0] c1_ff; // Shadow of control one
  logic [7:0] c2_ff; // Shadow of control two; standby clears by hardware are not tracked
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadows follow accepted writes only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      c1_ff <= 8'h00;
      c2_ff <= 8'h00;
    end
    else if (reg_wr && clk_en && reg_addr == 3'h2)
      c1_ff <= reg_wdata;
    else if (reg_wr && clk_en && reg_addr == 3'h3)
      c2_ff <= reg_wdata;
  end
  rx_irq_a: assert property (c2_ff[5] && rx_buffer_full |-> irq)
    else $error("receive full irq missing");
  idle_irq_a: assert property (c2_ff[4] && idle_flag |-> irq)
    else $error("idle irq missing");
  irq_quiet_a: assert property (c2_ff[7:4] == 4'h0 |-> !irq)
    else $error("irq with all enables off");
  rx_enable_a: assert property (reg_wr && clk_en && reg_addr == 3'h3 |=> rx_active == $past(reg_wdata[2]))
    else $error("receive enable not applied");
  rx_free_a: assert property (!c2_ff[2] |-> !rxd_owned)
    else $error("receive pin held while off");
  loop_free_a: assert property (c1_ff[7] |-> !rxd_owned)
    else $error("receive pin held in loop");
  tx_own_a: assert property (reg_wr && clk_en && reg_addr == 3'h3 && reg_wdata[3] && !c1_ff[7] |=> txd_oe)
    else $error("transmit pin not driven");
  read_back_a: assert property (reg_rd && clk_en && reg_addr == 3'h3 |=> reg_rdata_ff[7:2] == c2_ff[7:2])
    else $error("control read back differs");
  cover property (irq && c2_ff[5]);
  cover property (c1_ff[7] && c2_ff[2]);
  cover property ($fell(txd_oe));
endmodule // ucb_ctrl_sva
`default_nettype wire

// ===== tb/ucb_partner.sv
// Remote side of the transmit line: pull-up plus a low-run meter.
// Assumes the far end never drives the line itself.
`timescale 1ns/1ps
`default_nettype none
module ucb_partner (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic txd_out,
  input wire logic txd_oe,
  output logic txd_in,
  output logic [15:0] low_len_ff,
  output logic [7:0] runs_ff
);
  logic [15:0] cnt_ff; // Cycles of the current low run
  // Pull-up keeps the line high once the port lets go
  assign txd_in = txd_oe ? txd_out : 1'b1;
  // Each finished low run (a break) is measured and counted
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_ff <= 16'h0000;
      low_len_ff <= 16'h0000;
      runs_ff <= 8'h00;
    end
    else if (!txd_in)
      cnt_ff <= cnt_ff + 16'h0001;
    else if (cnt_ff != 16'h0000)
    begin
      low_len_ff <= cnt_ff;
      runs_ff <= runs_ff + 8'h01;
      cnt_ff <= 16'h0000;
    end
  end
endmodule // ucb_partner
`default_nettype wire

// ===== tb/tb_top.sv
// Directed bench for the serial port control block.
// Assumes divisor 1 gives a bit time of 16 bus clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BIT = 16; // Bus clocks per bit at divisor 1
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_buffer_full = 1'b0;
  logic idle_flag = 1'b0;
  logic [4:0] rx_error_flags = 5'h05; // Low four bits show in status
  logic rx_idle_detect = 1'b0;
  logic rx_msb_mark = 1'b0;
  logic rx_char_done = 1'b0;
  wire [7:0] reg_rdata_ff;
  wire txd_in, txd_out, txd_oe, rxd_owned, rx_active, rx_line, irq;
  wire [15:0] low_len;
  wire [7:0] runs;
  logic [7:0] rd_val;
  int err_total = 0;
  int tests_run = 0;
  ucb_ctrl u_ucb_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .rx_buffer_full(rx_buffer_full), .idle_flag(idle_flag), .rx_error_flags(rx_error_flags),
    .rx_idle_detect(rx_idle_detect), .rx_msb_mark(rx_msb_mark), .rx_char_done(rx_char_done),
    .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_owned(rxd_owned),
    .rx_active(rx_active), .rx_line(rx_line), .irq(irq));
  ucb_partner u_ucb_partner (.clk_sys(clk_sys), .reset_n(reset_n), .txd_out(txd_out), .txd_oe(txd_oe),
    .txd_in(txd_in), .low_len_ff(low_len), .runs_ff(runs));
  // 100 MHz bus clock
  always #5 clk_sys = ~clk_sys;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One-cycle write; ends just after the edge that takes it
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // One-cycle read; data stands only in the following cycle
  task rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata_ff;
  endtask
  // Bounded wait on the partner's run count or on pin release
  task wait_for(input logic [7:0] n, input logic for_release);
    int i;
    for (i = 0; i < 3000 && (for_release ? txd_oe !== 1'b0 : runs !== n); i++)
      @(posedge clk_sys);
    if (i == 3000)
    begin
      err_total++;
      results();
    end
  endtask
  task t_status;
    rd(3'h4);
    chk(rd_val, 8'hc5);
    wr(3'h4, 8'h00);
    rd(3'h4);
    chk(rd_val, 8'hc5);
  endtask
  task t_regs;
    rd(3'h3);
    chk(rd_val, 8'h00);
    wr(3'h3, 8'hf5);
    rd(3'h3);
    chk(rd_val, 8'hf5);
  endtask
  // Flags change at an edge, then the enable is written
  task irq_case(input logic [7:0] en, input logic rbf, input logic idl, input logic exp);
    @(posedge clk_sys);
    rx_buffer_full <= rbf;
    idle_flag <= idl;
    wr(3'h3, en);
    chk(irq, exp);
  endtask
  task t_irq;
    irq_case(8'h80, 1'b0, 1'b0, 1'b1);
    irq_case(8'h40, 1'b0, 1'b0, 1'b1);
    irq_case(8'h20, 1'b0, 1'b1, 1'b0);
    irq_case(8'h20, 1'b1, 1'b0, 1'b1);
    irq_case(8'h10, 1'b1, 1'b0, 1'b0);
    irq_case(8'h10, 1'b0, 1'b1, 1'b1);
    irq_case(8'h00, 1'b1, 1'b1, 1'b0);
  endtask
  task t_pins;
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h0c);
    chk({txd_oe, rxd_owned, rx_active}, 3'h7);
    wr(3'h2, 8'h80);
    chk(rxd_owned, 1'b0);
    wr(3'h2, 8'ha0);
    wr(3'h6, 8'h00);
    chk(txd_oe, 1'b0);
    wr(3'h6, 8'h20);
    chk(txd_oe, 1'b1);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h08);
    chk({rxd_owned, rx_active}, 2'h0);
  endtask
  task wake_pulse;
    @(posedge clk_sys);
    rx_idle_detect <= 1'b1;
    rx_char_done <= 1'b1;
    @(posedge clk_sys);
    rx_idle_detect <= 1'b0;
    rx_char_done <= 1'b0;
  endtask
  task t_standby;
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h06);
    rd(3'h3);
    chk(rd_val[1], 1'b1);
    wake_pulse();
    rd(3'h3);
    chk(rd_val[1], 1'b0);
    wr(3'h2, 8'h08);
    wr(3'h3, 8'h06);
    wake_pulse();
    rd(3'h3);
    chk(rd_val[1], 1'b1);
    @(posedge clk_sys);
    rx_msb_mark <= 1'b1;
    wake_pulse();
    rx_msb_mark <= 1'b0;
    rd(3'h3);
    chk(rd_val[1], 1'b0);
  endtask
  // Normal then long break; either one or two breaks may follow
  task t_break;
    int i;
    logic [7:0] base;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(3'h5, i ? 8'h04 : 8'h00);
      base = runs;
      wr(3'h3, 8'h09);
      wr(3'h3, 8'h08);
      wr(3'h3, 8'h00);
      chk(txd_oe, 1'b1);
      wait_for(base + 8'h01, 1'b0);
      chk(low_len >= (i ? 13 : 10) * BIT - 2 && low_len <= (i ? 14 : 11) * BIT + 2, 1'b1);
      wait_for(8'h00, 1'b1);
      chk(txd_in, 1'b1);
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_status();
    t_regs();
    t_irq();
    t_pins();
    t_standby();
    t_break();
    results();
  end
endmodule // tb_top
bind ucb_ctrl ucb_ctrl_sva u_ucb_ctrl_sva (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .rx_buffer_full(rx_buffer_full), .idle_flag(idle_flag), .txd_oe(txd_oe), .rxd_owned(rxd_owned),
  .rx_active(rx_active), .irq(irq));
`default_nettype wire
